// *** hdl/iwa_bus_if.sv ***
/*
 * two-wire bus carrier between host and device ends.
 * assumes open-drain wiring: the line is low when any end drives it.
 */
`timescale 1ns/1ns
interface iwa_bus_if;
	logic hostSclOe;
	logic hostSdaOe;
	logic devSdaOe;
	wire logic scl;
	wire logic sda;
	// pull-up resolution; any enabled driver pulls low
	assign scl = ~hostSclOe;
	assign sda = ~(hostSdaOe | devSdaOe);
	modport device (input scl, input sda, output devSdaOe);
	modport host (input scl, input sda, output hostSclOe, output hostSdaOe);
endinterface : iwa_bus_if

// *** hdl/iwa_device.sv ***
/*
 * device end of the word access port: decodes start/stop, matches the
 * slave address, takes a two- or three-byte sub-address and moves 16-bit
 * words to and from the internal register/memory port.
 * assumes the memory answers reads combinationally within one cycle.
 */
`timescale 1ns/1ns
module iwa_device
	import iwa_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bus side
	iwa_bus_if.device bus,
	// strap
	input wire logic slaveAddressSelect,
	// internal word port
	output logic memWrite,
	output logic memRead,
	output logic [18:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic [15:0] memRdata
);
	typedef enum {ST_IDLE, ST_SLA, ST_SUB0, ST_SUB1, ST_SUB2, ST_WDATA,
		ST_RDATA, ST_ACK, ST_MACK, ST_SKIP} iwa_dst_t;

	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers, then edge detection on the second stage
	logic [1:0] sclSync_r;
	logic [1:0] sdaSync_r;
	logic sclPrev_r;
	logic sdaPrev_r;
	always_ff @(posedge clock) begin
		sclSync_r <= {sclSync_r[0], bus.scl};
		sdaSync_r <= {sdaSync_r[0], bus.sda};
		sclPrev_r <= sclSync_r[1];
		sdaPrev_r <= sdaSync_r[1];
	end
	wire logic sclS = sclSync_r[1];
	wire logic sdaS = sdaSync_r[1];
	wire logic sclRise = sclS & ~sclPrev_r;
	wire logic sclFall = ~sclS & sclPrev_r;
	wire logic startSeen = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
	wire logic stopSeen = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

	////////////////////////////////////////////////////////////////////////
	// state
	iwa_dst_t state_r;
	iwa_dst_t state_nxt;
	iwa_dst_t after_r;	// state after the acknowledge slot
	logic [7:0] shift_r;
	logic [3:0] bitCnt_r;
	logic [18:0] addr_r;
	logic incDis_r;
	logic hiByte_r;	// second byte of the current word
	logic [7:0] lowByte_r;
	logic [15:0] rdWord_r;
	logic ackSend_r;
	logic sdaOe_r;
	logic wr_r;
	logic rd_r;
	logic [15:0] wdata_r;

	// slave address compare against strap-selected low bit
	wire logic [6:0] ownAddr = {TARGET_ADDRESS_HI, slaveAddressSelect};
	wire logic byteDone = sclRise & (bitCnt_r == 4'h7);
	wire logic [7:0] byteIn = {shift_r[6:0], sdaS};
	wire logic addrHit = (byteIn[7:1] == ownAddr);
	wire logic [18:0] addrInc = addr_r + ADDR_STEP;
	// byte being shifted out, low byte of the word first
	wire logic [7:0] curByte = hiByte_r ? rdWord_r[15:8] : rdWord_r[7:0];

	////////////////////////////////////////////////////////////////////////
	// byte receive / transmit sequencing
	always_ff @(posedge clock) begin
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		if (rst) begin
			state_r <= ST_IDLE;
			after_r <= ST_IDLE;
			shift_r <= 8'h00;
			bitCnt_r <= 4'h0;
			addr_r <= 19'h00000;
			incDis_r <= 1'b0;
			hiByte_r <= 1'b0;
			lowByte_r <= 8'h00;
			rdWord_r <= 16'h0000;
			ackSend_r <= 1'b0;
			sdaOe_r <= 1'b0;
			wdata_r <= 16'h0000;
		end else if (stopSeen) begin
			state_r <= ST_IDLE;	// release the line on stop
			sdaOe_r <= 1'b0;
		end else if (startSeen) begin
			state_r <= ST_SLA;	// repeated start keeps addr_r
			bitCnt_r <= 4'h0;
			hiByte_r <= 1'b0;
			sdaOe_r <= 1'b0;
		end else begin
			unique case (state_r)
			ST_IDLE, ST_SKIP: sdaOe_r <= 1'b0;
			ST_SLA, ST_SUB0, ST_SUB1, ST_SUB2, ST_WDATA: begin
				if (sclRise) begin
					shift_r <= byteIn;
					bitCnt_r <= bitCnt_r + 4'h1;
				end
				if (byteDone) begin
					state_r <= ST_ACK;
					ackSend_r <= 1'b1;
					unique case (state_r)
					ST_SLA: begin
						ackSend_r <= addrHit;
						if (!addrHit)
							after_r <= ST_SKIP;
						else if (byteIn[0] == RW_READ) begin
							after_r <= ST_RDATA;
							rdWord_r <= memRdata;
							rd_r <= 1'b1;
						end else
							after_r <= ST_SUB0;
					end
					ST_SUB0: begin
						ackSend_r <= ~byteIn[0];
						after_r <= byteIn[0] ? ST_SKIP : ST_SUB1;
						// an odd byte is refused and never kept
						if (!byteIn[0])
							addr_r[7:0] <= byteIn;
					end
					ST_SUB1: begin
						addr_r[13:8] <= byteIn[5:0];
						incDis_r <= byteIn[INCREMENT_DISABLE_BIT];
						after_r <= byteIn[SUBADDRESS_LENGTH_BIT] ?
							ST_SUB2 : ST_WDATA;
						if (!byteIn[SUBADDRESS_LENGTH_BIT])
							addr_r[18:14] <= 5'h00;
					end
					ST_SUB2: begin
						addr_r[18:14] <= byteIn[4:0];
						after_r <= ST_WDATA;
					end
					default: begin	// ST_WDATA, acked each byte
						after_r <= ST_WDATA;
						if (!hiByte_r)
							lowByte_r <= byteIn;
						else begin
							wdata_r <= {byteIn, lowByte_r};
							wr_r <= 1'b1;
						end
						hiByte_r <= ~hiByte_r;
					end
					endcase
				end
			end
			ST_ACK: begin
				// drive acknowledge through the ninth clock
				if (sclFall && !sdaOe_r && bitCnt_r == 4'h8) begin
					sdaOe_r <= ackSend_r;
					bitCnt_r <= 4'h9;
				end else if (sclFall && bitCnt_r == 4'h9) begin
					bitCnt_r <= 4'h0;
					state_r <= after_r;
					sdaOe_r <= (after_r == ST_RDATA) & ~rdWord_r[7];
				end
			end
			ST_RDATA: begin
				// shift out low byte then high byte
				if (sclFall) begin
					bitCnt_r <= bitCnt_r + 4'h1;
					if (bitCnt_r == 4'h7) begin
						sdaOe_r <= 1'b0;
						state_r <= ST_MACK;
					end else
						sdaOe_r <= ~curByte[3'(6 - bitCnt_r)];
				end
			end
			ST_MACK: begin
				// host ack continues, nack ends the read
				if (sclRise && bitCnt_r == 4'h8)
					state_r <= sdaS ? ST_SKIP : ST_MACK;
				if (sclRise)
					bitCnt_r <= 4'h9;
				if (sclFall && bitCnt_r == 4'h9) begin
					bitCnt_r <= 4'h0;
					state_r <= ST_RDATA;
					hiByte_r <= ~hiByte_r;
					if (hiByte_r) begin
						rdWord_r <= memRdata;
						rd_r <= 1'b1;
						sdaOe_r <= ~memRdata[7];
					end else
						sdaOe_r <= ~rdWord_r[15];
				end
			end
			endcase
			// step the address after every completed word unless incDis_r is set; a write steps
			// one cycle after its commit pulse so memAddr still shows the
			// word's own address, a read steps on the ninth rising clock
			// so the next word is fetched from the new address
			if (wr_r && !incDis_r)
				addr_r <= addrInc;
			if (state_r == ST_MACK && sclRise && bitCnt_r == 4'h8 &&
				hiByte_r && !incDis_r)
				addr_r <= addrInc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign bus.devSdaOe = sdaOe_r;
	assign memWrite = wr_r;
	assign memRead = rd_r;
	assign memAddr = addr_r;
	assign memWdata = wdata_r;
endmodule : iwa_device

// *** hdl/iwa_host.sv ***
/*
 * host end: bus master that sets a sub-address and writes or reads
 * 16-bit words, low byte first.
 * assumes the device end on the same carrier; one command at a time.
 */
`timescale 1ns/1ns
module iwa_host
	import iwa_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bus side
	iwa_bus_if.host bus,
	// command port
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdRead,
	input wire logic cmdLong,
	input wire logic cmdNoInc,
	input wire logic cmdPoll,
	input wire logic addrSelect,
	input wire logic [18:0] cmdAddr,
	input wire logic [3:0] cmdWords,
	input wire logic [15:0] wrWord,
	output logic wrTake,
	output logic [15:0] rdWord,
	output logic rdValid,
	output logic nackSeen
);
	typedef enum {HS_IDLE, HS_START, HS_BYTE, HS_ACK, HS_STOP}
		iwa_hst_t;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] sdaSync_r;
	always_ff @(posedge clock)
		sdaSync_r <= {sdaSync_r[0], bus.sda};

	iwa_hst_t state_r;
	logic [9:0] tick_r;
	logic [1:0] phase_r;
	logic [3:0] bit_r;
	logic [7:0] byte_r;
	logic [3:0] seq_r;	// byte index in transaction
	logic [3:0] words_r;
	logic hiByte_r;
	logic rdMode_r;
	logic sclOe_r;
	logic sdaOe_r;
	logic [15:0] word_r;
	logic [15:0] rd_r;
	logic rdv_r;
	logic take_r;
	logic nack_r;
	logic rdCmd_r;
	logic long_r;
	logic noinc_r;
	logic slave_address_select_r;
	logic [18:0] a_r;

	wire logic tick = (tick_r == QUARTER_CNT);
	// last read byte is left unacknowledged, then stop follows
	wire logic lastByte = rdMode_r & hiByte_r & (words_r == 4'h1);

	// next byte to send, by sequence position
	function automatic logic [7:0] seqByte(input logic [3:0] s);
		unique case (s)
		4'h0: seqByte = {TARGET_ADDRESS_HI, slave_address_select_r, RW_WRITE};
		4'h1: seqByte = a_r[7:0];
		4'h2: seqByte = {noinc_r, long_r, a_r[13:8]};
		4'h3: seqByte = {3'h0, a_r[18:14]};
		default: seqByte = {TARGET_ADDRESS_HI, slave_address_select_r, RW_READ};
		endcase
	endfunction : seqByte

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		rdv_r <= 1'b0;
		take_r <= 1'b0;
		if (rst) begin
			state_r <= HS_IDLE;
			tick_r <= 10'h000;
			phase_r <= 2'h0;
			bit_r <= 4'h0;
			byte_r <= 8'h00;
			seq_r <= 4'h0;
			words_r <= 4'h0;
			hiByte_r <= 1'b0;
			rdMode_r <= 1'b0;
			sclOe_r <= 1'b0;
			sdaOe_r <= 1'b0;
			word_r <= 16'h0000;
			rd_r <= 16'h0000;
			nack_r <= 1'b0;
			{rdCmd_r, long_r, noinc_r, slave_address_select_r} <= 4'h0;
			a_r <= 19'h00000;
		end else if (state_r == HS_IDLE) begin
			if (cmdValid) begin
				{rdCmd_r, long_r, noinc_r} <= {cmdRead, cmdLong, cmdNoInc};
				slave_address_select_r <= addrSelect;
				a_r <= cmdAddr;
				words_r <= cmdWords;
				word_r <= wrWord;
				take_r <= ~cmdRead;
				seq_r <= cmdPoll ? 4'h4 : 4'h0;
				nack_r <= 1'b0;
				state_r <= HS_START;
				phase_r <= 2'h0;
				tick_r <= 10'h000;
			end
		end else begin
			tick_r <= tick ? 10'h000 : tick_r + 10'h001;
			if (tick) begin
				phase_r <= phase_r + 2'h1;
				unique case (state_r)
				HS_START: begin
					// release, then sda low while scl high, then scl low
					unique case (phase_r)
					2'h0: {sclOe_r, sdaOe_r} <= 2'b00;
					2'h1: sdaOe_r <= 1'b1;
					2'h2: sclOe_r <= 1'b1;
					default: begin
						byte_r <= seqByte(seq_r);
						bit_r <= 4'h0;
						rdMode_r <= 1'b0;
						hiByte_r <= 1'b0;
						state_r <= HS_BYTE;
					end
					endcase
				end
				HS_BYTE, HS_ACK: begin
					// phase 0 set data, 1 scl high, 2 sample, 3 scl low
					unique case (phase_r)
					2'h0:
						if (state_r == HS_BYTE)
							sdaOe_r <= ~rdMode_r & ~byte_r[7];
						else
							sdaOe_r <= rdMode_r & ~lastByte;
					2'h1: sclOe_r <= 1'b0;
					2'h2:
						if (state_r == HS_BYTE)
							byte_r <= {byte_r[6:0], sdaSync_r[1]};
						else if (!rdMode_r && sdaSync_r[1])
							nack_r <= 1'b1;
					default: begin
						// let go of sda with the falling clock so the far
						// end never fights us for the ninth bit or the
						// next byte
						sclOe_r <= 1'b1;
						if (state_r == HS_BYTE) begin
							bit_r <= bit_r + 4'h1;
							if (bit_r == 4'h7) begin
								sdaOe_r <= 1'b0;
								state_r <= HS_ACK;
							end
						end else begin
							sdaOe_r <= 1'b0;
							ackDone();
						end
					end
					endcase
				end
				default: begin	// HS_STOP
					unique case (phase_r)
					2'h0: sdaOe_r <= 1'b1;
					2'h1: sclOe_r <= 1'b0;
					2'h2: sdaOe_r <= 1'b0;
					default: state_r <= HS_IDLE;
					endcase
				end
				endcase
			end
		end
	end

	// after an acknowledge slot pick the next byte or condition
	task automatic ackDone();
		bit_r <= 4'h0;
		if (nack_r || (!rdMode_r && sdaSync_r[1])) begin
			state_r <= HS_STOP;
		end else if (rdMode_r) begin
			if (hiByte_r) begin
				rd_r <= {byte_r, rd_r[7:0]};
				rdv_r <= 1'b1;
				words_r <= words_r - 4'h1;
			end else
				rd_r[7:0] <= byte_r;
			hiByte_r <= ~hiByte_r;
			state_r <= lastByte ? HS_STOP : HS_BYTE;
		end else if (seq_r == 4'h4) begin
			rdMode_r <= 1'b1;
			state_r <= HS_BYTE;
		end else if (seq_r == 4'h2 && !long_r || seq_r == 4'h3) begin
			if (rdCmd_r) begin
				seq_r <= 4'h4;
				state_r <= HS_START;
			end else begin
				seq_r <= 4'h5;
				byte_r <= word_r[7:0];
				hiByte_r <= 1'b0;
				state_r <= HS_BYTE;
			end
		end else if (seq_r >= 4'h5) begin
			if (!hiByte_r) begin
				byte_r <= word_r[15:8];
				hiByte_r <= 1'b1;
				state_r <= HS_BYTE;
			end else if (words_r > 4'h1) begin
				words_r <= words_r - 4'h1;
				word_r <= wrWord;
				take_r <= 1'b1;
				byte_r <= wrWord[7:0];
				hiByte_r <= 1'b0;
				state_r <= HS_BYTE;
			end else
				state_r <= HS_STOP;
		end else begin
			seq_r <= seq_r + 4'h1;
			byte_r <= seqByte(seq_r + 4'h1);
			state_r <= HS_BYTE;
		end
	endtask : ackDone

	assign cmdReady = (state_r == HS_IDLE);
	assign bus.hostSclOe = sclOe_r;
	assign bus.hostSdaOe = sdaOe_r;
	assign wrTake = take_r;
	assign rdWord = rd_r;
	assign rdValid = rdv_r;
	assign nackSeen = nack_r;
endmodule : iwa_host

// *** hdl/iwa_pkg.sv ***
/*
 * shared constants for the two-wire word access port: slave address,
 * sub-address field positions and bus timing counts.
 * assumes a 250 MHz system clock on both ends.
 */
package iwa_pkg;
	localparam int CLK_MHZ = 250;
	// fixed upper six bits of the seven-bit slave address
	localparam logic [5:0] TARGET_ADDRESS_HI = 6'h0d;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	// sub-address byte 1 control bit positions
	localparam int SUBADDRESS_LENGTH_BIT = 6;
	localparam int INCREMENT_DISABLE_BIT = 7;
	localparam int ADDR_W = 19;
	localparam logic [18:0] ADDR_STEP = 19'h00002;
	// host quarter-bit time in ns (400 kHz bus, 2.5 us bit)
	localparam int QUARTER_NS = 625;
	localparam int QUARTER_CYC = (QUARTER_NS * CLK_MHZ) / 1000;
	localparam logic [9:0] QUARTER_CNT = 10'(QUARTER_CYC);
endpackage : iwa_pkg

// *** sim/i2c_word_access_slave_port_tb.sv ***
/*
 * self-checking bench: host and device ends joined by the carrier.
 * assumes a memory that answers reads combinationally.
 */
`timescale 1ns/1ns
module i2c_word_access_slave_port_tb;
	import iwa_pkg::*;
	logic clock, rst, cmdValid, cmdReady, cmdRead, cmdLong, cmdNoInc;
	logic cmdPoll, addrSelect, slaveAddressSelect, wrTake, rdValid;
	logic nackSeen, memWrite, memRead, wrIdx;
	logic [18:0] cmdAddr, memAddr;
	logic [3:0] cmdWords;
	logic [15:0] wrWord, rdWord, memWdata, memRdata;
	logic [15:0] wrData [2];
	logic [34:0] wrQ [$];
	logic [15:0] rdQ [$];
	int failures, num_checks, mrCnt, cyc;
	////////////////////////////////////////////////////////////////////////
	iwa_bus_if bus();
	iwa_host iwa_host_i (.clock(clock), .rst(rst), .bus(bus.host),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
		.cmdLong(cmdLong), .cmdNoInc(cmdNoInc), .cmdPoll(cmdPoll),
		.addrSelect(addrSelect), .cmdAddr(cmdAddr), .cmdWords(cmdWords),
		.wrWord(wrWord), .wrTake(wrTake), .rdWord(rdWord),
		.rdValid(rdValid), .nackSeen(nackSeen));
	iwa_device iwa_device_i (.clock(clock), .rst(rst), .bus(bus.device),
		.slaveAddressSelect(slaveAddressSelect), .memWrite(memWrite),
		.memRead(memRead), .memAddr(memAddr), .memWdata(memWdata),
		.memRdata(memRdata));
	iwa_bus_properties iwa_bus_properties_i (.clock(clock), .rst(rst),
		.hostSdaOe(bus.hostSdaOe), .devSdaOe(bus.devSdaOe), .scl(bus.scl),
		.sda(bus.sda), .memWrite(memWrite), .memRead(memRead),
		.memAddr(memAddr));
	// memory content is a fixed function of the address
	assign memRdata = memAddr[15:0] ^ 16'hc35a;
	assign wrWord = wrData[wrIdx];
	////////////////////////////////////////////////////////////////////////
	// 4 ns clock
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	// record memory traffic and read words; cut a hang short. the
	// scenarios need about 120k cycles at 628 cycles a bus bit
	always @(posedge clock) begin
		cyc++;
		if (wrTake) wrIdx <= ~wrIdx;
		if (memWrite) wrQ.push_back({memAddr, memWdata});
		if (memRead) mrCnt++;
		if (rdValid) rdQ.push_back(rdWord);
		if (cyc == 130000) begin
			failures++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [34:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one command: present it while idle, drop valid after the edge
	// that takes it, then wait for idle again; ready is only looked at
	// 1 ns after an edge, where it is settled
	task automatic run(input logic rd, lng, ni, pl, sel,
		input logic [18:0] a, input logic [3:0] n);
		wrQ.delete();
		rdQ.delete();
		mrCnt = 0;
		while (cmdReady !== 1'b1) begin
			@(posedge clock);
			#1;
		end
		{cmdRead, cmdLong, cmdNoInc} = {rd, lng, ni};
		{cmdPoll, addrSelect} = {pl, sel};
		{cmdAddr, cmdWords, cmdValid, wrIdx} = {a, n, 2'b10};
		@(posedge clock);
		#1 cmdValid = 0;
		do begin
			@(posedge clock);
			#1;
		end while (cmdReady !== 1'b1);
	endtask : run
	task t_long_write;
		wrData[0] = 16'hbeef;
		wrData[1] = 16'h0a55;
		run(0, 1, 0, 0, 1, 19'h5a3c4, 4'h2);
		chk("wr nack", nackSeen, 0);
		chk("wr count", wrQ.size(), 2);
		chk("wr 0", wrQ[0], {19'h5a3c4, 16'hbeef});
		chk("wr 1", wrQ[1], {19'h5a3c6, 16'h0a55});
	endtask : t_long_write
	task t_read_poll;
		run(1, 0, 1, 0, 1, 19'h01234, 4'h1);
		chk("rd count", rdQ.size(), 1);
		chk("rd 0", rdQ[0], 16'hd16e);
		run(1, 0, 1, 1, 1, 19'h00000, 4'h1);
		chk("poll", rdQ[0], 16'hd16e);
		chk("poll nack", nackSeen, 0);
	endtask : t_read_poll
	// odd sub-address, then the other slave address: both refused
	task t_refused;
		run(0, 0, 0, 0, 1, 19'h00011, 4'h1);
		chk("odd nack", nackSeen, 1);
		chk("odd wr", wrQ.size(), 0);
		run(1, 0, 0, 0, 0, 19'h00010, 4'h1);
		chk("sel nack", nackSeen, 1);
		chk("sel mem", mrCnt + rdQ.size(), 0);
	endtask : t_refused
	task final_report;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////////////
	// reset for 12 cycles, then the scenarios
	initial begin
		{rst, cmdValid, cmdRead, cmdLong, cmdNoInc, cmdPoll} = 6'h20;
		{addrSelect, slaveAddressSelect, wrIdx, cmdAddr, cmdWords} = '0;
		slaveAddressSelect = 1;
		wrData[0] = 16'h0000;
		wrData[1] = 16'h0000;
		repeat (12) @(posedge clock);
		#1 rst = 0;
		t_long_write();
		t_read_poll();
		t_refused();
		final_report();
	end
endmodule : i2c_word_access_slave_port_tb

// *** sim/iwa_bus_properties.sv ***
/*
 * checker for the two-wire carrier and the device memory port.
 * assumes one clock domain; instantiated beside the carrier.
 */
`timescale 1ns/1ns
module iwa_bus_properties (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// carrier
	input wire logic hostSdaOe,
	input wire logic devSdaOe,
	input wire logic scl,
	input wire logic sda,
	// device memory port
	input wire logic memWrite,
	input wire logic memRead,
	input wire logic [18:0] memAddr
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	// sda may move only under low scl, else it forms a start or stop
	AST_DEV_SDA_SCL_LOW: assert property (
		$changed(devSdaOe) |-> !scl) else $error("device sda moved, scl high");
	// both ends pulling at once means a bit slot was misjudged
	AST_NO_CONTENTION: assert property (
		!(hostSdaOe && devSdaOe)) else $error("both ends drive sda");
	// for eight cycles after a stop the device keeps the line released
	AST_STOP_RELEASE: assert property (
		(scl && $rose(sda)) |=> !devSdaOe [*8])
		else $error("device drives sda after stop");
	// word writes and reads land only on even addresses
	AST_WR_EVEN: assert property (
		memWrite |-> !memAddr[0]) else $error("odd write address");
	AST_RD_EVEN: assert property (
		memRead |-> !memAddr[0]) else $error("odd read address");
	// commit is a single pulse per word
	AST_WR_PULSE: assert property (
		memWrite |=> !memWrite) else $error("write pulse too long");
	AST_RD_PULSE: assert property (
		memRead |=> !memRead) else $error("read pulse too long");
	AST_WR_RD_APART: assert property (
		!(memWrite && memRead)) else $error("write and read together");
endmodule : iwa_bus_properties
